// >>> cbcc_bus_controller.sv
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// - Mode input high selects I/O-bus mode, low selects system-bus mode.
// - All command and control outputs are registered on the processor clock.
// - Commands and controls come from decoding the three status inputs.
// - Direction output high for writes, low for reads.
// - Address strobe pulses so latches capture address on its falling edge.
// - System-bus mode: commands enabled 3 clock cycles (105 ns rounded up to 150 ns) after arbitration enable asserts.
// - Memory commands, and I/O commands in system-bus mode, float while arbitration enable is deasserted.
// - Memory read command is driven active low.
// - Advanced memory write starts early, timed like the read commands.
// - Normal memory write starts later than the advanced memory write.
// - Advanced I/O write starts earlier than the normal I/O write.
// - Command enable high lets outputs work; low holds them inactive.
// - Data enable connects the transceivers during data transfers.
// - System-bus mode: shared pin is cascade enable during interrupt acknowledge.
// - I/O-bus mode: shared pin is the peripheral data enable for I/O cycles.
// - Status 000 ack, 001 I/O read, 010 I/O writes, 100/101/110 memory, 011/111 none.
// - I/O-bus mode: I/O commands stay enabled regardless of arbitration enable.
// - Address strobe occurs every machine cycle, halt included.
module cbcc_bus_controller
(
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic [2:0]                 cpu_status_lines,
  input  wire logic                       io_bus_mode_select,
  input  wire logic                       command_output_enable,
  input  wire logic                       arbitration_enable_n,
  output logic                            address_latch_strobe,
  output logic                            transfer_direction,
  output logic                            transceiver_data_enable,
  output logic                            cascade_or_peripheral_enable,
  output logic                            memory_read_cmd_n,
  output logic                            memory_write_cmd_n,
  output logic                            early_memory_write_n,
  output logic                            io_read_cmd_n,
  output logic                            io_write_cmd_n,
  output logic                            early_io_write_n,
  output logic                            interrupt_ack_strobe_n,
  output logic                            mem_cmd_oe,
  output logic                            io_cmd_oe,
  input  wire logic [cbcc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest
);

  // ----------------------------------------
  // Status decode
  // ----------------------------------------
  function automatic logic cbcc_is_read(input logic [2:0] code);
    cbcc_is_read = (code == cbcc_pkg::ST_INTERRUPT_ACK_STROBE) || (code == cbcc_pkg::ST_IO_RD) ||
                   (code == cbcc_pkg::ST_CODE) || (code == cbcc_pkg::ST_MEM_RD);
  endfunction : cbcc_is_read

  function automatic logic cbcc_is_io(input logic [2:0] code);
    cbcc_is_io = (code == cbcc_pkg::ST_INTERRUPT_ACK_STROBE) || (code == cbcc_pkg::ST_IO_RD) ||
                 (code == cbcc_pkg::ST_IO_WR);
  endfunction : cbcc_is_io

  // ----------------------------------------
  // State
  // ----------------------------------------
  cbcc_pkg::cbcc_phase_t              phase;
  cbcc_pkg::cbcc_phase_t              next_phase;
  logic [2:0]                         code;
  logic [2:0]                         next_code;
  logic [cbcc_pkg::AEN_CNT_W-1:0]     aen_cnt;
  logic [cbcc_pkg::AEN_CNT_W-1:0]     next_aen_cnt;
  logic                               ctrl_enable;
  logic                               next_ctrl_enable;
  logic                               ack;
  logic                               next_ack;
  logic [31:0]                        next_readdata;
  logic                               next_ale;
  logic                               next_dtr;
  logic                               next_den;
  logic                               next_shared;
  logic                               next_memory_read_cmd_n;
  logic                               next_memory_write_cmd_n;
  logic                               next_early_memory_write_n;
  logic                               next_io_read_cmd_n;
  logic                               next_io_write_cmd_n;
  logic                               next_early_io_write_n;
  logic                               next_interrupt_ack_strobe_n;
  logic                               next_mem_oe;
  logic                               next_io_oe;
  logic                               cmd_on;
  logic                               early;
  logic                               late;
  logic                               xfer;
  logic                               aen_ok;

  // ----------------------------------------
  // Machine cycle sequencer
  // ----------------------------------------
  always_comb
  begin
    next_phase = phase;
    next_code  = code;
    case (phase)
      cbcc_pkg::PH_IDLE:
      begin
        if (cpu_status_lines != cbcc_pkg::ST_PASSIVE)
        begin
          next_phase = cbcc_pkg::PH_T1;
          next_code  = cpu_status_lines;
        end
      end
      cbcc_pkg::PH_T1:
        next_phase = cbcc_pkg::PH_T2;
      cbcc_pkg::PH_T2:
        next_phase = (cpu_status_lines == cbcc_pkg::ST_PASSIVE) ?
                     cbcc_pkg::PH_IDLE : cbcc_pkg::PH_T3;
      cbcc_pkg::PH_T3:
      begin
        if (cpu_status_lines == cbcc_pkg::ST_PASSIVE)
        begin
          next_phase = cbcc_pkg::PH_IDLE;
          next_code  = cbcc_pkg::ST_PASSIVE;
        end
      end
      default:
        next_phase = cbcc_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      phase <= cbcc_pkg::PH_IDLE;
      code  <= cbcc_pkg::ST_PASSIVE;
    end
    else
    begin
      phase <= next_phase;
      code  <= next_code;
    end
  end

  // ----------------------------------------
  // Arbitration enable delay
  // ----------------------------------------
  // count cycles since asserted
  always_comb
  begin
    next_aen_cnt = '0;
    if (!arbitration_enable_n)
    begin
      next_aen_cnt = aen_ok ? aen_cnt : aen_cnt + cbcc_pkg::AEN_CNT_W'(1);
    end
  end

  assign aen_ok = (aen_cnt == cbcc_pkg::AEN_CNT_W'(cbcc_pkg::AEN_DELAY_CYC));

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      aen_cnt <= '0;
    else
      aen_cnt <= next_aen_cnt;
  end

  // ----------------------------------------
  // Command and control outputs
  // ----------------------------------------
  // Outputs follow next_phase so they line up with the registered phase
  always_comb
  begin
    cmd_on = command_output_enable && ctrl_enable;
    early  = (next_phase == cbcc_pkg::PH_T2) || (next_phase == cbcc_pkg::PH_T3);
    late   = (next_phase == cbcc_pkg::PH_T3);
    xfer   = (next_phase != cbcc_pkg::PH_IDLE) && (next_code != cbcc_pkg::ST_HALT) &&
             (next_code != cbcc_pkg::ST_PASSIVE);

    next_memory_read_cmd_n  = ~(cmd_on && early && (next_code == cbcc_pkg::ST_CODE ||
                                         next_code == cbcc_pkg::ST_MEM_RD));
    next_early_memory_write_n  = ~(cmd_on && early && next_code == cbcc_pkg::ST_MEM_WR);
    next_memory_write_cmd_n  = ~(cmd_on && late  && next_code == cbcc_pkg::ST_MEM_WR);
    next_io_read_cmd_n  = ~(cmd_on && early && next_code == cbcc_pkg::ST_IO_RD);
    next_early_io_write_n = ~(cmd_on && early && next_code == cbcc_pkg::ST_IO_WR);
    next_io_write_cmd_n  = ~(cmd_on && late  && next_code == cbcc_pkg::ST_IO_WR);
    next_interrupt_ack_strobe_n  = ~(cmd_on && early && next_code == cbcc_pkg::ST_INTERRUPT_ACK_STROBE);

    next_ale = cmd_on && (next_phase == cbcc_pkg::PH_T1);
    // direction from T1, ahead of enable
    next_dtr = ~(cmd_on && xfer && cbcc_is_read(next_code));
    next_den = cmd_on && early && xfer &&
               !(io_bus_mode_select && cbcc_is_io(next_code));
    if (io_bus_mode_select)
    begin
      next_shared = ~(cmd_on && early && xfer && cbcc_is_io(next_code));
    end
    else
    begin
      next_shared = cmd_on && next_code == cbcc_pkg::ST_INTERRUPT_ACK_STROBE &&
                    (next_phase == cbcc_pkg::PH_T1 || next_phase == cbcc_pkg::PH_T2);
    end

    next_mem_oe = (next_aen_cnt == cbcc_pkg::AEN_CNT_W'(cbcc_pkg::AEN_DELAY_CYC));
    next_io_oe  = io_bus_mode_select || next_mem_oe;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      address_latch_strobe         <= 1'b0;
      transfer_direction           <= 1'b1;
      transceiver_data_enable      <= 1'b0;
      cascade_or_peripheral_enable <= 1'b0;
      memory_read_cmd_n            <= 1'b1;
      memory_write_cmd_n           <= 1'b1;
      early_memory_write_n         <= 1'b1;
      io_read_cmd_n                <= 1'b1;
      io_write_cmd_n               <= 1'b1;
      early_io_write_n             <= 1'b1;
      interrupt_ack_strobe_n       <= 1'b1;
      mem_cmd_oe                   <= 1'b0;
      io_cmd_oe                    <= 1'b0;
    end
    else
    begin
      address_latch_strobe         <= next_ale;
      transfer_direction           <= next_dtr;
      transceiver_data_enable      <= next_den;
      cascade_or_peripheral_enable <= next_shared;
      memory_read_cmd_n            <= next_memory_read_cmd_n;
      memory_write_cmd_n           <= next_memory_write_cmd_n;
      early_memory_write_n         <= next_early_memory_write_n;
      io_read_cmd_n                <= next_io_read_cmd_n;
      io_write_cmd_n               <= next_io_write_cmd_n;
      early_io_write_n             <= next_early_io_write_n;
      interrupt_ack_strobe_n       <= next_interrupt_ack_strobe_n;
      mem_cmd_oe                   <= next_mem_oe;
      io_cmd_oe                    <= next_io_oe;
    end
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  always_comb
  begin
    next_ack         = (avs_read || avs_write) && !ack;
    next_ctrl_enable = ctrl_enable;
    next_readdata    = avs_readdata;
    if (avs_write && ack && avs_address == cbcc_pkg::REG_CONTROL && avs_byteenable[0])
    begin
      next_ctrl_enable = avs_writedata[cbcc_pkg::CTRL_EN_BIT];
    end
    if (avs_read && !ack)
    begin
      next_readdata = 32'h0;
      if (avs_address == cbcc_pkg::REG_CONTROL)
      begin
        next_readdata[cbcc_pkg::CTRL_EN_BIT] = ctrl_enable;
      end
      else if (avs_address == cbcc_pkg::REG_STATUS)
      begin
        next_readdata[cbcc_pkg::STS_CEN_BIT] = command_output_enable;
        next_readdata[cbcc_pkg::STS_AEN_BIT] = aen_ok;
        next_readdata[cbcc_pkg::STS_IOB_BIT] = io_bus_mode_select;
        next_readdata[cbcc_pkg::STS_CODE_LSB +: 3] = code;
        next_readdata[cbcc_pkg::STS_FSM_LSB +: 2]  = phase;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ack          <= 1'b0;
      ctrl_enable  <= cbcc_pkg::CONTROL_RST;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack          <= next_ack;
      ctrl_enable  <= next_ctrl_enable;
      avs_readdata <= next_readdata;
    end
  end

endmodule : cbcc_bus_controller

// >>> cbcc_pkg.sv
package cbcc_pkg;

  // ----------------------------------------
  // Processor status encodings
  // ----------------------------------------
  localparam logic [2:0] ST_INTERRUPT_ACK_STROBE    = 3'h0;
  localparam logic [2:0] ST_IO_RD   = 3'h1;
  localparam logic [2:0] ST_IO_WR   = 3'h2;
  localparam logic [2:0] ST_HALT    = 3'h3;
  localparam logic [2:0] ST_CODE    = 3'h4;
  localparam logic [2:0] ST_MEM_RD  = 3'h5;
  localparam logic [2:0] ST_MEM_WR  = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int AEN_DELAY_NS  = 105;
  localparam int AEN_DELAY_CYC = (AEN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AEN_CNT_W     = $clog2(AEN_DELAY_CYC + 1);

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  REG_CONTROL  = 3'h0;
  localparam logic [2:0]  REG_STATUS   = 3'h4;
  localparam logic        CONTROL_RST  = 1'b1;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          STS_CEN_BIT  = 0;
  localparam int          STS_AEN_BIT  = 1;
  localparam int          STS_IOB_BIT  = 2;
  localparam int          STS_CODE_LSB = 4;
  localparam int          STS_FSM_LSB  = 8;

  // ----------------------------------------
  // Machine cycle phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_T1   = 2'b01,
    PH_T2   = 2'b10,
    PH_T3   = 2'b11
  } cbcc_phase_t;

endpackage : cbcc_pkg

// >>> cbcc_bus_controller_checker.sv
`timescale 1ns/1ns
module cbcc_bus_controller_checker
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [2:0] cpu_status_lines,
  input wire logic       io_bus_mode_select,
  input wire logic       command_output_enable,
  input wire logic       arbitration_enable_n,
  input wire logic       address_latch_strobe,
  input wire logic       transfer_direction,
  input wire logic       transceiver_data_enable,
  input wire logic       cascade_or_peripheral_enable,
  input wire logic       memory_read_cmd_n,
  input wire logic       memory_write_cmd_n,
  input wire logic       early_memory_write_n,
  input wire logic       io_read_cmd_n,
  input wire logic       io_write_cmd_n,
  input wire logic       early_io_write_n,
  input wire logic       interrupt_ack_strobe_n,
  input wire logic       mem_cmd_oe,
  input wire logic       io_cmd_oe
);
  logic       last_idle;
  logic       next_last_idle;
  logic       start;
  logic       off;
  logic [2:0] st;
  assign st = cpu_status_lines;
  // Start only after a passive sample, so a mid-cycle code is not a new cycle
  always_comb next_last_idle = reset | (st == 3'h7);
  always_ff @(posedge clk_sys) last_idle <= next_last_idle;
  assign start = last_idle && st != 3'h7 && command_output_enable;
  assign off = &{memory_read_cmd_n, memory_write_cmd_n, early_memory_write_n, io_read_cmd_n,
                 io_write_cmd_n, early_io_write_n, interrupt_ack_strobe_n};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_ale; start |=> address_latch_strobe ##1 !address_latch_strobe; endproperty
  a_ale: assert property (p_ale) else $error("strobe not one pulse");
  property p_mwr; start && st == 3'h6 |=> transfer_direction && early_memory_write_n
    ##1 !early_memory_write_n && memory_write_cmd_n ##1 !memory_write_cmd_n; endproperty
  a_mwr: assert property (p_mwr) else $error("memory write order");
  property p_iowr; start && st == 3'h2 |=> transfer_direction && early_io_write_n
    ##1 !early_io_write_n && io_write_cmd_n ##1 !io_write_cmd_n; endproperty
  a_iowr: assert property (p_iowr) else $error("io write order");
  property p_mrd; start && st[2] && !st[1] |=> !transfer_direction
    ##1 !memory_read_cmd_n && transceiver_data_enable && io_read_cmd_n; endproperty
  a_mrd: assert property (p_mrd) else $error("memory read");
  property p_idle; $past(st) inside {3'h3, 3'h7} |-> off; endproperty
  a_idle: assert property (p_idle) else $error("command while idle");
  property p_cen; !$past(command_output_enable) |-> off && !transceiver_data_enable; endproperty
  a_cen: assert property (p_cen) else $error("command while disabled");
  property p_aen_on; $fell(arbitration_enable_n) |=> !mem_cmd_oe [*2] ##[1:2] mem_cmd_oe;
  endproperty
  a_aen_on: assert property (p_aen_on) else $error("enable delay");
  property p_aen_off; arbitration_enable_n |=> !mem_cmd_oe; endproperty
  a_aen_off: assert property (p_aen_off) else $error("not floated");
  property p_iob; io_bus_mode_select |=> io_cmd_oe; endproperty
  a_iob: assert property (p_iob) else $error("io commands floated");
  property p_casc; start && st == 3'h0 && !io_bus_mode_select
    |=> cascade_or_peripheral_enable [*2] ##1 !cascade_or_peripheral_enable; endproperty
  a_casc: assert property (p_casc) else $error("cascade enable");
  c_wr: cover property (start && st == 3'h6);
  c_ack: cover property (start && st == 3'h0);
  c_iob: cover property (start && io_bus_mode_select);
endmodule : cbcc_bus_controller_checker
bind cbcc_bus_controller cbcc_bus_controller_checker cbcc_bus_controller_checker_inst (.*);

// >>> cbcc_cpu_model.sv
`timescale 1ns/1ns
module cbcc_cpu_model
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       issue,
  input  wire logic [2:0] code,
  output logic      [2:0] cpu_status_lines
);
  logic [2:0] left;
  always_ff @(posedge clk_sys)
  begin
    left <= reset ? 3'h0 : issue ? 3'h4 : left - 3'(left != 3'h0);
    if (reset || left == 3'h1)
      cpu_status_lines <= 3'h7;
    else if (issue)
      cpu_status_lines <= code;
  end
endmodule : cbcc_cpu_model

// >>> cpu_bus_command_controller_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module cpu_bus_command_controller_tb_top;
  logic        clk_sys = 1'h0;
  logic        reset = 1'h1;
  logic [2:0]  cpu_status_lines;
  logic        io_bus_mode_select = 1'h0;
  logic        command_output_enable = 1'h1;
  logic        arbitration_enable_n = 1'h1;
  logic        address_latch_strobe, transfer_direction, transceiver_data_enable;
  logic        cascade_or_peripheral_enable, mem_cmd_oe, io_cmd_oe;
  logic        memory_read_cmd_n, memory_write_cmd_n, early_memory_write_n;
  logic        io_read_cmd_n, io_write_cmd_n, early_io_write_n, interrupt_ack_strobe_n;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest;
  logic        issue = 1'h0;
  logic [2:0]  code = 3'h7;
  logic [6:0]  cmds;
  int          err_count = 0;
  int          checked = 0;
  assign cmds = {memory_read_cmd_n, early_memory_write_n, memory_write_cmd_n, io_read_cmd_n,
                 early_io_write_n, io_write_cmd_n, interrupt_ack_strobe_n};
  cbcc_bus_controller cbcc_bus_controller_inst (.*);
  cbcc_cpu_model cbcc_cpu_model_inst (.*);
  initial forever #25 clk_sys = ~clk_sys;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  function automatic logic [6:0] exp_cmds(input logic [2:0] c);
    case (c)
      cbcc_pkg::ST_INTERRUPT_ACK_STROBE:   return 7'h7e;
      cbcc_pkg::ST_IO_RD:  return 7'h77;
      cbcc_pkg::ST_IO_WR:  return 7'h79;
      cbcc_pkg::ST_CODE,
      cbcc_pkg::ST_MEM_RD: return 7'h3f;
      cbcc_pkg::ST_MEM_WR: return 7'h4f;
      default:             return 7'h7f;
    endcase
  endfunction : exp_cmds
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int   n;
    logic w;
    n = 0;
    w = 1'h1;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    while (w && n < 20)
    begin
      @(posedge clk_sys);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
    end
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (w)
    begin
      err_count++;
      conclude();
    end
  endtask : bus
  task automatic run_cycle(input logic [2:0] c);
    @(posedge clk_sys);
    issue <= 1'h1;
    code <= c;
    @(posedge clk_sys);
    issue <= 1'h0;
    @(posedge clk_sys);
    #1;
    `CHK(address_latch_strobe, command_output_enable)
    if (command_output_enable && c inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6})
      `CHK(transfer_direction, c[1])
    @(posedge clk_sys);
    #1;
    `CHK(cascade_or_peripheral_enable, io_bus_mode_select ? !(command_output_enable && c < 3'h3) :
         (command_output_enable && c == 3'h0))
    @(posedge clk_sys);
    #1;
    `CHK(cmds, command_output_enable ? exp_cmds(c) : 7'h7f)
    `CHK(transceiver_data_enable, command_output_enable && c != 3'h3 &&
         !(io_bus_mode_select && c < 3'h3))
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({cmds, transfer_direction}, 8'hff)
  endtask : run_cycle
  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    #1;
    `CHK({address_latch_strobe, transfer_direction, transceiver_data_enable, cmds}, 10'h17f)
    bus(1'h0, cbcc_pkg::REG_CONTROL, 32'h0, 4'hf);
    `CHK(q[0], cbcc_pkg::CONTROL_RST)
    bus(1'h1, cbcc_pkg::REG_CONTROL, 32'h0, 4'h0);
    bus(1'h0, cbcc_pkg::REG_CONTROL, 32'h0, 4'hf);
    `CHK(q[0], 1'h1)
    bus(1'h1, cbcc_pkg::REG_CONTROL, 32'h0, 4'hf);
    bus(1'h0, cbcc_pkg::REG_CONTROL, 32'h0, 4'hf);
    `CHK(q[0], 1'h0)
    bus(1'h1, cbcc_pkg::REG_CONTROL, 32'h1, 4'hf);
    bus(1'h1, 3'h2, 32'hffffffff, 4'hf);
    bus(1'h0, 3'h2, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    bus(1'h0, cbcc_pkg::REG_STATUS, 32'h0, 4'hf);
    `CHK(q[2:0], 3'h1)
    arbitration_enable_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(mem_cmd_oe, 1'h0)
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(mem_cmd_oe, 1'h1)
    for (int c = 0; c < 7; c++)
      run_cycle(3'(c));
    @(posedge clk_sys);
    command_output_enable <= 1'h0;
    run_cycle(cbcc_pkg::ST_MEM_RD);
    @(posedge clk_sys);
    command_output_enable <= 1'h1;
    arbitration_enable_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(mem_cmd_oe, 1'h0)
    @(posedge clk_sys);
    io_bus_mode_select <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK({io_cmd_oe, mem_cmd_oe}, 2'h2)
    for (int c = 0; c < 7; c++)
      run_cycle(3'(c));
    conclude();
  end
endmodule : cpu_bus_command_controller_tb_top
